// ---- hdl/latch8_pkg.sv ----
// package for the serial-to-parallel latch block: widths and reset values
// assumes a single core clock; pin inputs are synchronised inside the block
package latch8_pkg;
   localparam int          STAGE_COUNT = 8;      // shift and storage width
   localparam logic [7:0]  CLEAR_VALUE = 8'h00;  // value forced by a clear
   localparam int          SYNC_DEPTH  = 2;      // flops on each pin input
   localparam logic [1:0]  SYNC_RESET  = 2'h0;   // synchroniser reset value
endpackage

// ---- hdl/serial_to_parallel_latch8.sv ----
// serial-in parallel-out shift register feeding an eight-bit storage register
// assumes all pins are asynchronous to core_clk; clock pins are sampled and
// their rising edges detected, so each pin level must last over two cycles
// clears are sampled the same way and act after the same two-flop delay
//
// Contract
// - an eight-stage shift register feeds a separate eight-bit store.
// - shift and store clocks are independent and act on rising edges.
// - with tied clocks the store holds shift contents one edge older.
// - each register has its own clear that overrides its clock.
// - while shift clear is low all shift stages are zero.
// - a shift rise moves serial in to the first stage and each stage on.
// - a falling shift clock edge leaves the shift register unchanged.
// - while storage clear is low all storage bits are zero.
// - a storage clock rise loads the storage register from the shift.
// - a falling storage clock edge leaves the storage register unchanged.
// - a serial output from the shift register allows chaining.
`timescale 1ns/10ps
module serial_to_parallel_latch8 #(
   parameter int WIDTH = latch8_pkg::STAGE_COUNT
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic             serial_in,
   input  wire logic             shift_clock,
   input  wire logic             shift_clear_n,
   input  wire logic             store_clock,
   input  wire logic             store_clear_n,
   output logic                  cascade_out,
   output logic [WIDTH-1:0]      parallel_out
);
   import latch8_pkg::*;

   // two-flop synchronisers, first flop read only by the second
   // metastability hazard: nothing else may ever read a first flop
   // costs two cycles of latency on every pin, clocks and data alike
   logic [1:0] sync_data;
   logic [1:0] sync_sclk;
   logic [1:0] sync_sclr;
   logic [1:0] sync_rclk;
   logic [1:0] sync_store_clear_n;
   logic       sclk_prev;
   logic       rclk_prev;
   logic [1:0] next_sync_data;
   logic [1:0] next_sync_sclk;
   logic [1:0] next_sync_sclr;
   logic [1:0] next_sync_rclk;
   logic [1:0] next_sync_store_clear_n;
   logic       next_sclk_prev;
   logic       next_rclk_prev;

   always_comb begin
      next_sync_data = {sync_data[0], serial_in};
      next_sync_sclk = {sync_sclk[0], shift_clock};
      next_sync_sclr = {sync_sclr[0], shift_clear_n};
      next_sync_rclk = {sync_rclk[0], store_clock};
      next_sync_store_clear_n = {sync_store_clear_n[0], store_clear_n};
      next_sclk_prev = sync_sclk[1];
      next_rclk_prev = sync_rclk[1];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sync_data <= SYNC_RESET;
         sync_sclk <= SYNC_RESET;
         sync_sclr <= SYNC_RESET;
         sync_rclk <= SYNC_RESET;
         sync_store_clear_n <= SYNC_RESET;
         sclk_prev <= 1'b0;
         rclk_prev <= 1'b0;
      end else begin
         sync_data <= next_sync_data;
         sync_sclk <= next_sync_sclk;
         sync_sclr <= next_sync_sclr;
         sync_rclk <= next_sync_rclk;
         sync_store_clear_n <= next_sync_store_clear_n;
         sclk_prev <= next_sclk_prev;
         rclk_prev <= next_rclk_prev;
      end
   end

   // edge detect on the second flops only; falling edges do nothing
   // prev flops reset low like the idle clock pins, so no false edge
   logic shift_rise;
   logic store_rise;
   logic shift_clr;
   logic store_clr;
   assign shift_rise = sync_sclk[1] && !sclk_prev;
   assign store_rise = sync_rclk[1] && !rclk_prev;
   assign shift_clr  = !sync_sclr[1];
   assign store_clr  = !sync_store_clear_n[1];

   // shift and storage registers
   logic [WIDTH-1:0] shift_reg;
   logic [WIDTH-1:0] store_reg;
   logic [WIDTH-1:0] next_shift_reg;
   logic [WIDTH-1:0] next_store_reg;
   logic             next_cascade_out;
   logic [WIDTH-1:0] next_parallel_out;

   // the clear is level-sensitive and wins over any clock edge
   always_comb begin
      next_shift_reg = shift_reg;
      if (shift_clr) begin
         next_shift_reg = CLEAR_VALUE[WIDTH-1:0];
      end else if (shift_rise) begin
         next_shift_reg = {shift_reg[WIDTH-2:0], sync_data[1]};
      end
   end

   // storage samples the old shift value, so tied clocks lag one edge
   always_comb begin
      next_store_reg = store_reg;
      if (store_clr) begin
         next_store_reg = CLEAR_VALUE[WIDTH-1:0];
      end else if (store_rise) begin
         next_store_reg = shift_reg;
      end
   end

   // outputs registered from the next values, so they track the registers
   // trade-off: a duplicate flop per output buys outputs straight from flops
   always_comb begin
      next_cascade_out  = next_shift_reg[WIDTH-1];
      next_parallel_out = next_store_reg;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         shift_reg    <= CLEAR_VALUE[WIDTH-1:0];
         store_reg    <= CLEAR_VALUE[WIDTH-1:0];
         cascade_out  <= CLEAR_VALUE[0];
         parallel_out <= CLEAR_VALUE[WIDTH-1:0];
      end else begin
         shift_reg    <= next_shift_reg;
         store_reg    <= next_store_reg;
         cascade_out  <= next_cascade_out;
         parallel_out <= next_parallel_out;
      end
   end

   // named sequences for the shift and store steps
   // checks sit on the synchronised view, after the pin delay
   // a clear or a step shows in the registers one edge later
   sequence s_shift_step;
      !shift_clr && shift_rise;
   endsequence

   sequence s_store_step;
      !store_clr && store_rise;
   endsequence

   property p_shift_clear;
      @(posedge core_clk) disable iff (!rst_b)
      shift_clr |=> (shift_reg == '0) && !cascade_out;
   endproperty
   a_shift_clear: assert property (p_shift_clear)
      else $error("shift register not cleared");

   property p_shift_step;
      @(posedge core_clk) disable iff (!rst_b)
      s_shift_step |=> shift_reg ==
         {$past(shift_reg[WIDTH-2:0]), $past(sync_data[1])};
   endproperty
   a_shift_step: assert property (p_shift_step)
      else $error("shift step wrong");

   property p_shift_hold;
      @(posedge core_clk) disable iff (!rst_b)
      (!shift_clr && !shift_rise) |=> $stable(shift_reg);
   endproperty
   a_shift_hold: assert property (p_shift_hold)
      else $error("shift register changed without rising edge");

   property p_store_clear;
      @(posedge core_clk) disable iff (!rst_b)
      store_clr |=> (store_reg == '0) && (parallel_out == '0);
   endproperty
   a_store_clear: assert property (p_store_clear)
      else $error("storage register not cleared");

   property p_store_load;
      @(posedge core_clk) disable iff (!rst_b)
      s_store_step |=> (store_reg == $past(shift_reg)) &&
         (parallel_out == $past(shift_reg));
   endproperty
   a_store_load: assert property (p_store_load)
      else $error("storage did not load shift contents");

   property p_store_hold;
      @(posedge core_clk) disable iff (!rst_b)
      (!store_clr && !store_rise) |=> $stable(store_reg);
   endproperty
   a_store_hold: assert property (p_store_hold)
      else $error("storage changed without rising edge");

   property p_tied_lag;
      @(posedge core_clk) disable iff (!rst_b)
      (s_shift_step and s_store_step) |=> store_reg == $past(shift_reg);
   endproperty
   a_tied_lag: assert property (p_tied_lag)
      else $error("storage not one edge behind");

   property p_cascade;
      @(posedge core_clk) disable iff (!rst_b)
      cascade_out == shift_reg[WIDTH-1];
   endproperty
   a_cascade: assert property (p_cascade)
      else $error("cascade output wrong");

   property p_parallel;
      @(posedge core_clk) disable iff (!rst_b)
      1'b1 |=> parallel_out == store_reg;
   endproperty
   a_parallel: assert property (p_parallel)
      else $error("parallel output not storage");

   // falling edges of either clock, seen while its clear is released;
   // both must pass without touching the register they clock
   sequence s_shift_fall;
      !shift_clr && !sync_sclk[1] && sclk_prev;
   endsequence

   sequence s_store_fall;
      !store_clr && !sync_rclk[1] && rclk_prev;
   endsequence

   property p_shift_fall;
      @(posedge core_clk) disable iff (!rst_b)
      s_shift_fall |=> $stable(shift_reg);
   endproperty
   a_shift_fall: assert property (p_shift_fall)
      else $error("shift register moved on a falling edge");

   property p_store_fall;
      @(posedge core_clk) disable iff (!rst_b)
      s_store_fall |=> $stable(store_reg);
   endproperty
   a_store_fall: assert property (p_store_fall)
      else $error("storage moved on a falling edge");

   // a clear and a rising edge in the same cycle: the clear wins,
   // since a sampled clear cannot act ahead of the edge as a pin would
   property p_shift_clear_wins;
      @(posedge core_clk) disable iff (!rst_b)
      (shift_clr && shift_rise) |=> (shift_reg == '0) && !cascade_out;
   endproperty
   a_shift_clear_wins: assert property (p_shift_clear_wins)
      else $error("shift clock beat the shift clear");

   property p_store_clear_wins;
      @(posedge core_clk) disable iff (!rst_b)
      (store_clr && store_rise) |=> (store_reg == '0) && (parallel_out == '0);
   endproperty
   a_store_clear_wins: assert property (p_store_clear_wins)
      else $error("storage clock beat the storage clear");

   // each clear is private to its register; the other one keeps
   // its contents unless its own clock rises
   property p_shift_alone;
      @(posedge core_clk) disable iff (!rst_b)
      (store_clr && !shift_clr && !shift_rise) |=> $stable(shift_reg);
   endproperty
   a_shift_alone: assert property (p_shift_alone)
      else $error("storage clear reached the shift register");

   property p_store_alone;
      @(posedge core_clk) disable iff (!rst_b)
      (shift_clr && !store_clr && !store_rise) |=> $stable(store_reg);
   endproperty
   a_store_alone: assert property (p_store_alone)
      else $error("shift clear reached the storage register");

   // the cascade pin shows the stage that was seventh before the shift,
   // which is what a chained device takes on its next edge
   property p_cascade_step;
      @(posedge core_clk) disable iff (!rst_b)
      s_shift_step |=> cascade_out == $past(shift_reg[WIDTH-2]);
   endproperty
   a_cascade_step: assert property (p_cascade_step)
      else $error("cascade output did not follow the shift");

   // one rising edge of a pin acts once: the detector is a single pulse,
   // so a slow pin level cannot shift or store twice
   property p_shift_pulse;
      @(posedge core_clk) disable iff (!rst_b)
      shift_rise |=> !shift_rise;
   endproperty
   a_shift_pulse: assert property (p_shift_pulse)
      else $error("shift edge acted twice");

   property p_store_pulse;
      @(posedge core_clk) disable iff (!rst_b)
      store_rise |=> !store_rise;
   endproperty
   a_store_pulse: assert property (p_store_pulse)
      else $error("storage edge acted twice");

   // tied clocks seen at the outputs: parallel out lags by one edge,
   // since the store samples the shift value from before the edge
   property p_tied_out;
      @(posedge core_clk) disable iff (!rst_b)
      (s_shift_step and s_store_step) |=> parallel_out == $past(shift_reg);
   endproperty
   a_tied_out: assert property (p_tied_out)
      else $error("parallel output not one edge behind");
endmodule

// ---- bench/byte_feeder.sv ----
// partner model: controller that shifts bytes into the latch block
// assumes core_clk is the block clock; pin changes land 1 ns after its rise
`timescale 1ns/10ps
module byte_feeder (
   input  wire logic core_clk,
   output logic      serial_in,
   output logic      shift_clock,
   output logic      store_clock
);
   initial begin
      serial_in   = 1'b0;
      shift_clock = 1'b0;
      store_clock = 1'b0;
   end

   // four cycles a level, one more than the pin synchronisers need
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // mode 0 shift then store, 1 clocks tied, 2 shift only
   task automatic send_byte(input logic [7:0] b, input int mode);
      for (int i = 7; i >= 0; i--) begin
         serial_in = b[i];
         wait_cyc(4);
         shift_clock = 1'b1;
         store_clock = (mode == 1);
         wait_cyc(4);
         shift_clock = 1'b0;
         store_clock = 1'b0;
         wait_cyc(4);
      end
      serial_in = ~serial_in; // released line shows no stale bit
      if (mode == 0) begin
         store_clock = 1'b1;
         wait_cyc(4);
         store_clock = 1'b0;
         wait_cyc(4);
      end
   endtask
endmodule

// ---- bench/serial_to_parallel_latch8_tb.sv ----
// self-checking bench for the serial-to-parallel latch block
// assumes the byte_feeder partner drives the serial and clock pins
`timescale 1ns/10ps
`define check(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
   fails++; $display("unexpected %s exp %h got %h", nm, exp, got); end end
module serial_to_parallel_latch8_tb;
   logic       core_clk, rst_b, serial_in, shift_clock, store_clock;
   logic       shift_clear_n, store_clear_n, cascade_out;
   logic [7:0] parallel_out;
   int         fails, n_checks;

   serial_to_parallel_latch8 u_serial_to_parallel_latch8 (
      .core_clk(core_clk), .rst_b(rst_b), .serial_in(serial_in),
      .shift_clock(shift_clock), .shift_clear_n(shift_clear_n),
      .store_clock(store_clock), .store_clear_n(store_clear_n),
      .cascade_out(cascade_out), .parallel_out(parallel_out));
   byte_feeder u_byte_feeder (.core_clk(core_clk), .serial_in(serial_in),
      .shift_clock(shift_clock), .store_clock(store_clock));

   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // shifting alone must not reach parallel_out, only cascade_out
   task automatic test_load;
      u_byte_feeder.send_byte(8'ha5, 2);
      `check("parallel_out", 8'h00, parallel_out)
      `check("cascade_out", 1'b1, cascade_out)
      u_byte_feeder.send_byte(8'h96, 0);
      `check("parallel_out", 8'h96, parallel_out)
      `check("cascade_out", 1'b1, cascade_out)
      $display("test_load done");
   endtask

   // each clear empties its own register and beats its own clock; the storage clear spares the shift register
   task automatic test_clear;
      shift_clear_n = 1'b0;
      u_byte_feeder.send_byte(8'hff, 0);
      `check("parallel_out", 8'h00, parallel_out)
      `check("cascade_out", 1'b0, cascade_out)
      shift_clear_n = 1'b1;
      store_clear_n = 1'b0;
      u_byte_feeder.send_byte(8'hc3, 0);
      `check("parallel_out", 8'h00, parallel_out)
      `check("cascade_out", 1'b1, cascade_out)
      store_clear_n = 1'b1;
      $display("test_clear done");
   endtask

   // tied clocks: storage lags one edge, keeping the newest bit of c3
   task automatic test_tied;
      u_byte_feeder.send_byte(8'h3c, 1);
      `check("parallel_out", 8'h9e, parallel_out)
      `check("cascade_out", 1'b0, cascade_out)
      $display("test_tied done");
   endtask

   initial begin
      fails         = 0;
      n_checks      = 0;
      rst_b         = 1'b0;
      shift_clear_n = 1'b1;
      store_clear_n = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      test_load();
      test_clear();
      test_tied();
      final_report();
   end

   // whole run is about 2.5 us; this cuts a hang well past that
   initial begin
      #20000;
      fails++;
      $display("unexpected timeout");
      final_report();
   end
endmodule
